// [hdl/gpr_regs.svh]
// addresses, field positions, reset values and codes of the gpio port registers
// Behaviour
// R1: software uses full 32-bit word accesses
// R2: four-bit nibble per pin, direction low
// R3: direction 0 input, 1 output
// R4: input codes analog, floating, pulled, reserved
// R5: output codes push-pull, open-drain, alternate push-pull
// R6: configuration resets to its default value
// R7: input levels in low byte, read-only
// R8: output latch drives pins, resets zero
// R9: pulled input: latch bit picks pull direction
// R10: set/clear register, set wins on collision
// R11: clear-only register clears latch bits
// R12: software writes key 1, 0, 1
// R13: faulty key sequence never engages lock
// R14: pin lock bits frozen once engaged
// R15: locked pins ignore configuration writes
// R16: ports spaced 0x400 apart from first base
// R17: pin levels sampled every clock
// R18: analog pins read level zero
// R19: alternate output driven by peripheral line
// R20: key sequence errors return to idle
// R21: strobe writes act at once, write-only reads zero
`ifndef GPR_REGS_SVH
`define GPR_REGS_SVH

`define GPR_PIN_COUNT 8
`define GPR_NIB_W 4

// register byte addresses of the first port
`define GPR_CFG_ADDR 32'h40010800
`define GPR_LEVEL_ADDR 32'h40010808
`define GPR_LATCH_ADDR 32'h4001080C
`define GPR_SETCLR_ADDR 32'h40010810
`define GPR_CLRONLY_ADDR 32'h40010814
`define GPR_LOCK_ADDR 32'h40010818
`define GPR_PORT_STRIDE 32'h00000400

// reset values
`define GPR_CFG_RESET 32'h04444444
`define GPR_LATCH_RESET 8'h00
`define GPR_PINLOCK_RESET 8'h00

// field positions
`define GPR_DIR_BIT 0
`define GPR_CFG_LSB 2
`define GPR_SET_LSB 0
`define GPR_CLR_LSB 16
`define GPR_KEY_BIT 16
`define GPR_CFG_WMASK 32'hDDDDDDDD

// pin configuration field codes
`define GPR_CFG_ANALOG 2'h0
`define GPR_CFG_FLOAT 2'h1
`define GPR_CFG_PULL 2'h2
`define GPR_CFG_PUSHPULL 2'h0
`define GPR_CFG_OPENDRAIN 2'h1
`define GPR_CFG_ALTPP 2'h2
`define GPR_CFG_ALTOD 2'h3

`endif

// [hdl/gpr_pkg.sv]
// types and shared decode functions of the gpio port
`include "gpr_regs.svh"
package gpr_pkg;

  // lock key sequence steps, one-hot
  typedef enum logic [3:0] {
    LK_IDLE = 4'h1,
    LK_ONE = 4'h2,
    LK_ZERO = 4'h4,
    LK_LOCKED = 4'h8
  } gpr_lock_state_t;

  typedef logic [`GPR_NIB_W-1:0] gpr_nibble_t;

  // nibble of one pin out of the configuration word
  function automatic gpr_nibble_t gpr_nibble(input logic [31:0] cfg, input int idx);
    gpr_nibble_t n;
    n = cfg[idx*`GPR_NIB_W +: `GPR_NIB_W];
    return n;
  endfunction

  // widen per-pin flags to whole nibbles
  function automatic logic [31:0] gpr_lock_mask(input logic [7:0] pins);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < `GPR_PIN_COUNT; i++) begin
      m[i*`GPR_NIB_W +: `GPR_NIB_W] = {`GPR_NIB_W{pins[i]}};
    end
    return m;
  endfunction

  // address match for one register of this port instance
  function automatic logic gpr_hit(input logic [31:0] addr, input logic [31:0] regAddr,
                                   input logic [31:0] portOfs);
    return addr == (regAddr + portOfs);
  endfunction

endpackage

// [hdl/gpr_lock_seq.sv]
// lock key sequence and per-pin lock bits
`timescale 1ns/1ps
module gpr_lock_seq
  import gpr_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic lockWrite,
  input wire logic wrKey,
  input wire logic [7:0] wrPins,
  output logic [7:0] pinLock,
  output logic lockActive
);

  gpr_lock_state_t state_reg;
  gpr_lock_state_t state_next;
  logic [7:0] pinLock_reg;
  logic samePins;

  assign samePins = (wrPins == pinLock_reg);
  assign pinLock = pinLock_reg;
  assign lockActive = (state_reg == LK_LOCKED);

  // next step of the key sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LK_IDLE: begin
        if (lockWrite && wrKey) begin
          state_next = LK_ONE;
        end
      end
      LK_ONE: begin
        if (lockWrite) begin
          state_next = (!wrKey && samePins) ? LK_ZERO : LK_IDLE; // see R20
        end
      end
      LK_ZERO: begin
        if (lockWrite) begin
          state_next = (wrKey && samePins) ? LK_LOCKED : LK_IDLE; // see R13
        end
      end
      LK_LOCKED: begin
        state_next = LK_LOCKED;
      end
      default: begin
        state_next = LK_IDLE;
      end
    endcase
  end

  // sequence state, released only by reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= LK_IDLE; // see R20
    end else begin
      state_reg <= state_next;
    end
  end

  // pin lock bits writable until engaged
  always_ff @(posedge mclk) begin
    if (reset) begin
      pinLock_reg <= `GPR_PINLOCK_RESET;
    end else if (lockWrite && !lockActive) begin
      pinLock_reg <= wrPins; // see R14
    end
  end

endmodule

// [hdl/gpr_pin_ctrl.sv]
// per-pin driver, pull and analog control from configuration and latch
`timescale 1ns/1ps
module gpr_pin_ctrl
  import gpr_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [31:0] cfg,
  input wire logic [7:0] latch,
  input wire logic [7:0] altOut,
  output logic [7:0] pinOut,
  output logic [7:0] pinOutEnN,
  output logic [7:0] pullUpEn,
  output logic [7:0] pullDownEn,
  output logic [7:0] analogSel
);

  // registered pin controls, one pass per pin
  always_ff @(posedge mclk) begin
    if (reset) begin
      pinOut <= 8'h00;
      pinOutEnN <= 8'hFF;
      pullUpEn <= 8'h00;
      pullDownEn <= 8'h00;
      analogSel <= 8'h00;
    end else begin
      for (int i = 0; i < `GPR_PIN_COUNT; i++) begin
        pinOut[i] <= 1'b0;
        pinOutEnN[i] <= 1'b1;
        pullUpEn[i] <= 1'b0;
        pullDownEn[i] <= 1'b0;
        analogSel[i] <= 1'b0;
        if (!cfg[i*`GPR_NIB_W + `GPR_DIR_BIT]) begin // see R3
          case (cfg[i*`GPR_NIB_W + `GPR_CFG_LSB +: 2]) // see R4
            `GPR_CFG_ANALOG: analogSel[i] <= 1'b1;
            `GPR_CFG_PULL: begin
              pullUpEn[i] <= latch[i]; // see R9
              pullDownEn[i] <= ~latch[i];
            end
            default: analogSel[i] <= 1'b0;
          endcase
        end else begin
          case (cfg[i*`GPR_NIB_W + `GPR_CFG_LSB +: 2]) // see R5
            `GPR_CFG_PUSHPULL: begin
              pinOut[i] <= latch[i]; // see R8
              pinOutEnN[i] <= 1'b0;
            end
            `GPR_CFG_OPENDRAIN: begin
              pinOutEnN[i] <= latch[i];
            end
            `GPR_CFG_ALTPP: begin
              pinOut[i] <= altOut[i]; // see R19
              pinOutEnN[i] <= 1'b0;
            end
            default: begin
              pinOutEnN[i] <= altOut[i];
            end
          endcase
        end
      end
    end
  end

endmodule

// [hdl/gpr_port.sv]
// gpio port register file with lock, top level
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module gpr_port
  import gpr_pkg::*;
#(
  parameter int PORT_INDEX = 0
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [31:0] busAddr,
  input wire logic [31:0] busWData,
  input wire logic busWrite,
  input wire logic busRead,
  output logic [31:0] busRData,
  input wire logic [7:0] pinIn,
  input wire logic [7:0] altOut,
  output logic [7:0] pinOut,
  output logic [7:0] pinOutEnN,
  output logic [7:0] pullUpEn,
  output logic [7:0] pullDownEn,
  output logic [7:0] analogSel,
  output logic lockEngaged
);

  // instance offset from the first port base
  localparam logic [31:0] PORT_OFS = 32'(PORT_INDEX) * `GPR_PORT_STRIDE; // see R16

  logic hitCfg;
  logic hitLevel;
  logic hitLatch;
  logic hitSetClr;
  logic hitClrOnly;
  logic hitLock;
  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  logic [7:0] latch_reg;
  logic [7:0] latch_next;
  logic [7:0] level_reg;
  logic [7:0] analogMask;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0] pinLock;
  logic lockActive;
  logic [31:0] frozenMask;

  // address decode of this instance
  assign hitCfg = gpr_hit(busAddr, `GPR_CFG_ADDR, PORT_OFS); // see R16
  assign hitLevel = gpr_hit(busAddr, `GPR_LEVEL_ADDR, PORT_OFS); // see R16
  assign hitLatch = gpr_hit(busAddr, `GPR_LATCH_ADDR, PORT_OFS);
  assign hitSetClr = gpr_hit(busAddr, `GPR_SETCLR_ADDR, PORT_OFS);
  assign hitClrOnly = gpr_hit(busAddr, `GPR_CLRONLY_ADDR, PORT_OFS);
  assign hitLock = gpr_hit(busAddr, `GPR_LOCK_ADDR, PORT_OFS);

  // nibbles that writes may no longer touch
  assign frozenMask = lockActive ? gpr_lock_mask(pinLock) : 32'h00000000;
  assign lockEngaged = lockActive;
  assign busRData = rdata_reg;

  // lock key sequence
  gpr_lock_seq lockSeq (
    .mclk(mclk),
    .reset(reset),
    .lockWrite(busWrite && hitLock),
    .wrKey(busWData[`GPR_KEY_BIT]),
    .wrPins(busWData[7:0]),
    .pinLock(pinLock),
    .lockActive(lockActive)
  );

  // pin drivers
  gpr_pin_ctrl pinCtrl (
    .mclk(mclk),
    .reset(reset),
    .cfg(cfg_reg),
    .latch(latch_reg),
    .altOut(altOut),
    .pinOut(pinOut),
    .pinOutEnN(pinOutEnN),
    .pullUpEn(pullUpEn),
    .pullDownEn(pullDownEn),
    .analogSel(analogSel)
  );

  // configuration write, reserved bits and locked nibbles kept
  always_comb begin
    cfg_next = cfg_reg;
    if (busWrite && hitCfg) begin
      cfg_next = ((busWData & `GPR_CFG_WMASK) & ~frozenMask) | (cfg_reg & frozenMask); // see R2
    end
  end

  // configuration register
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_reg <= `GPR_CFG_RESET; // see R6
    end else begin
      cfg_reg <= cfg_next; // see R15
    end
  end

  // output latch: plain write, set/clear, clear-only
  always_comb begin
    latch_next = latch_reg;
    if (busWrite && hitLatch) begin
      latch_next = busWData[7:0]; // see R8
    end else if (busWrite && hitSetClr) begin
      latch_next = (latch_reg & ~busWData[`GPR_CLR_LSB +: 8]) | busWData[`GPR_SET_LSB +: 8]; // see R10
    end else if (busWrite && hitClrOnly) begin
      latch_next = latch_reg & ~busWData[7:0]; // see R11
    end
  end

  // output latch register
  always_ff @(posedge mclk) begin
    if (reset) begin
      latch_reg <= `GPR_LATCH_RESET;
    end else begin
      latch_reg <= latch_next; // see R21
    end
  end

  // analog pins masked from the level sample
  always_comb begin
    analogMask = 8'h00;
    for (int i = 0; i < `GPR_PIN_COUNT; i++) begin
      analogMask[i] = !cfg_reg[i*`GPR_NIB_W + `GPR_DIR_BIT] &&
                      (cfg_reg[i*`GPR_NIB_W + `GPR_CFG_LSB +: 2] == `GPR_CFG_ANALOG);
    end
  end

  // pin levels sampled every clock
  always_ff @(posedge mclk) begin
    if (reset) begin
      level_reg <= 8'h00;
    end else begin
      level_reg <= pinIn & ~analogMask; // see R17 R18
    end
  end

  // read mux, write-only and unmapped read zero
  always_comb begin
    rdata_next = 32'h00000000;
    if (busRead) begin
      if (hitCfg) begin
        rdata_next = cfg_reg;
      end else if (hitLevel) begin
        rdata_next = {24'h000000, level_reg}; // see R7
      end else if (hitLatch) begin
        rdata_next = {24'h000000, latch_reg};
      end else if (hitLock) begin
        rdata_next = {15'h0000, lockActive, 8'h00, pinLock}; // see R13
      end else begin
        rdata_next = 32'h00000000; // see R21
      end
    end
  end

  // read data valid one cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // checks on the register file
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // configuration default after reset
  cfg_reset_a: assert property ($past(reset) |-> cfg_reg == `GPR_CFG_RESET) // see R6
    else $error("configuration not at reset default");

  // reserved nibble bits always zero
  cfg_reserved_a: assert property ((cfg_reg & ~`GPR_CFG_WMASK) == 32'h00000000) // see R2
    else $error("reserved configuration bit set");

  // level sample follows pins with analog masked
  level_sample_a: assert property (
    !$past(reset) |-> level_reg == ($past(pinIn) & ~$past(analogMask))) // see R17
    else $error("pin level sample wrong");

  // analog pin 0 reads zero one cycle on
  analog_zero_a: assert property (
    analogMask[0] && $stable(cfg_reg) |=> !level_reg[0]) // see R18
    else $error("analog pin level not zero");

  // set/clear write effect, set winning
  set_clear_a: assert property (
    busWrite && hitSetClr |=>
      latch_reg == (($past(latch_reg) & ~$past(busWData[23:16])) | $past(busWData[7:0])))
    // see R10
    else $error("set/clear result wrong");

  // clear-only write effect
  clear_only_a: assert property (
    busWrite && hitClrOnly |=> latch_reg == ($past(latch_reg) & ~$past(busWData[7:0])))
    // see R11
    else $error("clear-only result wrong");

  // plain latch write and read back
  latch_write_a: assert property (
    busWrite && hitLatch ##1 busRead && hitLatch ##1 1'b1 |->
      busRData == {24'h000000, $past(busWData[7:0], 2)}) // see R8
    else $error("latch read back wrong");

  // level read returns sample, upper bits zero
  level_read_a: assert property (
    busRead && hitLevel |=> busRData == {24'h000000, $past(level_reg)}) // see R7
    else $error("level read wrong");

  // write-only reads give zero
  wo_read_zero_a: assert property (
    busRead && (hitSetClr || hitClrOnly) |=> busRData == 32'h00000000) // see R21
    else $error("write-only read not zero");

  // read data only in the cycle after a read
  rdata_idle_a: assert property (!busRead |=> busRData == 32'h00000000)
    else $error("read data outside read answer");

  // lock stays engaged and pin lock bits frozen
  lock_sticky_a: assert property (lockActive |=> lockActive && $stable(pinLock)) // see R14
    else $error("lock released or pin lock changed");

  // locked nibbles ignore configuration writes
  cfg_frozen_a: assert property (
    lockActive |=> (cfg_reg & gpr_lock_mask(pinLock)) ==
                   ($past(cfg_reg) & gpr_lock_mask(pinLock))) // see R15
    else $error("locked configuration changed");

  // correct key sequence engages the lock
  key_good_a: assert property (
    !lockActive && busWrite && hitLock && busWData[16] ##1 !busWrite ##1
    busWrite && hitLock && !busWData[16] && busWData[7:0] == pinLock ##1 !busWrite ##1
    busWrite && hitLock && busWData[16] && busWData[7:0] == pinLock |=> lockActive) // see R13
    else $error("lock not engaged by good sequence");

  // key sequence with changed pins never engages
  key_bad_a: assert property (
    !lockActive && busWrite && hitLock && busWData[16] ##1 !busWrite ##1
    busWrite && hitLock && busWData[7:0] != pinLock ##1 !busWrite ##1
    busWrite && hitLock |=> !lockActive) // see R20
    else $error("lock engaged by faulty sequence");

  // push-pull pin 0 drives the latch one cycle on
  drive_pp_a: assert property (
    gpr_nibble(cfg_reg, 0) == 4'h1 && $stable(cfg_reg) && $stable(latch_reg) |=>
      !pinOutEnN[0] && pinOut[0] == $past(latch_reg[0])) // see R5
    else $error("push-pull pin not driving latch");

  // main scenarios
  lock_seen_c: cover property (!lockActive ##1 lockActive);
  set_clr_clash_c: cover property (
    busWrite && hitSetClr && (busWData[7:0] & busWData[23:16]) != 8'h00);
  level_read_c: cover property (busRead && hitLevel ##1 busRData[7:0] != 8'h00);
  locked_cfg_write_c: cover property (lockActive && busWrite && hitCfg && pinLock != 8'h00);

endmodule

// [verification/gpr_pin_model.sv]
// model of the circuitry on the port pins
`timescale 1ns/1ps
module gpr_pin_model
  import gpr_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOutEnN,
  input wire logic [7:0] pullUpEn,
  input wire logic [7:0] pullDownEn,
  input wire logic [7:0] extDrv,
  input wire logic [7:0] extEn,
  output logic [7:0] pinIn
);
  logic [7:0] floatPat = 8'h5A;
  // undriven lines wander every cycle
  always @(posedge mclk) begin
    floatPat <= ~floatPat;
  end
  // wire level: block driver, then outside driver, then pulls
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pinOutEnN[i] === 1'b0) pinIn[i] = pinOut[i];
      else if (extEn[i]) pinIn[i] = extDrv[i];
      else if (pullUpEn[i] === 1'b1) pinIn[i] = 1'b1;
      else if (pullDownEn[i] === 1'b1) pinIn[i] = 1'b0;
      else pinIn[i] = floatPat[i];
    end
  end
endmodule

// [verification/test_gpio_port_regs_lock.sv]
// self-checking bench of the gpio port register file
`timescale 1ns/1ps
`include "gpr_regs.svh"
module test_gpio_port_regs_lock
  import gpr_pkg::*;
;
  localparam logic [31:0] OFS = 32'h00000400;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] busAddr = 32'h0;
  logic [31:0] busWData = 32'h0;
  logic busWrite = 1'b0;
  logic busRead = 1'b0;
  logic [31:0] busRData;
  logic [7:0] pinIn;
  logic [7:0] altOut = 8'h00;
  logic [7:0] extDrv = 8'h00;
  logic [7:0] extEn = 8'h00;
  logic [7:0] pinOut, pinOutEnN, pullUpEn, pullDownEn, analogSel;
  logic lockEngaged;
  logic rdWait = 1'b0;
  logic [31:0] rdQ[$];
  logic [31:0] expV, d, l, s, c;
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 32'h722a;

  always #12.5 mclk = ~mclk;

  gpr_port #(.PORT_INDEX(1)) dut (
    .mclk(mclk), .reset(reset), .busAddr(busAddr), .busWData(busWData),
    .busWrite(busWrite), .busRead(busRead), .busRData(busRData), .pinIn(pinIn),
    .altOut(altOut), .pinOut(pinOut), .pinOutEnN(pinOutEnN), .pullUpEn(pullUpEn),
    .pullDownEn(pullDownEn), .analogSel(analogSel), .lockEngaged(lockEngaged)
  );

  gpr_pin_model pins (
    .mclk(mclk), .pinOut(pinOut), .pinOutEnN(pinOutEnN), .pullUpEn(pullUpEn),
    .pullDownEn(pullDownEn), .extDrv(extDrv), .extEn(extEn), .pinIn(pinIn)
  );

  // word write, one strobe cycle
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge mclk);
    busAddr <= a + OFS;
    busWData <= v;
    busWrite <= 1'b1;
    @(posedge mclk);
    busWrite <= 1'b0;
  endtask

  // word read, expected value queued for the monitor
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge mclk);
    busAddr <= a + OFS;
    busRead <= 1'b1;
    rdQ.push_back(e);
    @(posedge mclk);
    busRead <= 0;
  endtask

  // write then read back with no gap
  task automatic wrrd(input logic [31:0] a, input logic [31:0] v, input logic [31:0] e);
    @(posedge mclk);
    busAddr <= a + OFS;
    busWData <= v;
    busWrite <= 1'b1;
    @(posedge mclk);
    busWrite <= 1'b0;
    busRead <= 1'b1;
    rdQ.push_back(e);
    @(posedge mclk);
    busRead <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t direct got %h exp %h", $time, g, e);
    end
  endtask

  task automatic done(input string n);
    $display("test %s finished at %0t", n, $time);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // read data stand in the cycle after the strobe
  always @(posedge mclk) begin
    rdWait <= busRead;
  end
  always @(negedge mclk) begin
    if (rdWait) begin
      expV = rdQ.pop_front();
      tests_run++;
      if (busRData !== expV) begin
        n_mismatch++;
        $display("MISMATCH %0t read got %h exp %h", $time, busRData, expV);
      end
    end
  end

  // watchdog
  initial begin
    #(25 * 4000);
    n_mismatch++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    // reset values, write-only and unmapped places
    rd(`GPR_CFG_ADDR, `GPR_CFG_RESET);
    rd(`GPR_LATCH_ADDR, 32'h0);
    rd(`GPR_LOCK_ADDR, 32'h0);
    rd(`GPR_SETCLR_ADDR, 32'h0);
    rd(`GPR_CLRONLY_ADDR, 32'h0);
    rd(`GPR_CFG_ADDR - OFS, 32'h0);
    rd(`GPR_LOCK_ADDR + 32'h4, 32'h0);
    chk(analogSel, 8'h80);
    done("reset");
    // configuration reserved bits
    d = $random(seed);
    wr(`GPR_CFG_ADDR, d);
    rd(`GPR_CFG_ADDR, d & `GPR_CFG_WMASK);
    done("config");
    // latch, set/clear with collisions, clear-only
    for (int i = 0; i < 4; i++) begin
      l = $random(seed);
      s = $random(seed);
      c = $random(seed);
      wrrd(`GPR_LATCH_ADDR, l, l & 32'hFF);
      wr(`GPR_SETCLR_ADDR, {8'h00, c[7:0], 8'h00, s[7:0]});
      l = (l & ~c & 32'hFF) | s[7:0];
      rd(`GPR_LATCH_ADDR, l);
      wr(`GPR_CLRONLY_ADDR, c);
      rd(`GPR_LATCH_ADDR, l & ~c);
    end
    done("latch");
    // output codes: push-pull, open-drain, alternate, floating input
    wr(`GPR_CFG_ADDR, 32'h44995511);
    l = $random(seed);
    altOut <= $random(seed);
    extDrv <= $random(seed) | 8'h0C;
    extEn <= 8'hCC;
    wr(`GPR_LATCH_ADDR, l);
    repeat (4) @(posedge mclk);
    rd(`GPR_LEVEL_ADDR, {24'h0, extDrv[7:6], altOut[5:4], l[3:0]});
    done("outputs");
    // input codes: analog, floating, pull-up, pull-down
    wr(`GPR_CFG_ADDR, 32'h44448840);
    wr(`GPR_LATCH_ADDR, 32'h04);
    extEn <= 8'hF2;
    extDrv <= $random(seed);
    wr(`GPR_LEVEL_ADDR, 32'hFFFFFFFF);
    repeat (4) @(posedge mclk);
    rd(`GPR_LEVEL_ADDR, {24'h0, (extDrv & 8'hF2) | 8'h04});
    chk(analogSel, 8'h01);
    done("inputs");
    // faulty key sequence, pins change mid-way
    wr(`GPR_LOCK_ADDR, 32'h0001000F);
    wr(`GPR_LOCK_ADDR, 32'h0000000E);
    wr(`GPR_LOCK_ADDR, 32'h0001000E);
    rd(`GPR_LOCK_ADDR, 32'h0000000E);
    chk(lockEngaged, 0);
    wr(`GPR_LOCK_ADDR, 32'h0000000F);
    // proper key sequence locks pins 3..0
    wr(`GPR_LOCK_ADDR, 32'h0001000F);
    wr(`GPR_LOCK_ADDR, 32'h0000000F);
    wr(`GPR_LOCK_ADDR, 32'h0001000F);
    rd(`GPR_LOCK_ADDR, 32'h0001000F);
    chk(lockEngaged, 1);
    wr(`GPR_LOCK_ADDR, 32'h000100F0);
    rd(`GPR_LOCK_ADDR, 32'h0001000F);
    wr(`GPR_CFG_ADDR, 32'hFFFFFFFF);
    rd(`GPR_CFG_ADDR, 32'hDDDD8840);
    done("lock");
    // second reset releases the lock
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk(lockEngaged, 0);
    rd(`GPR_CFG_ADDR, `GPR_CFG_RESET);
    wr(`GPR_CFG_ADDR, 32'hFFFFFFFF);
    rd(`GPR_CFG_ADDR, 32'hDDDDDDDD);
    done("release");
    repeat (3) @(posedge mclk);
    end_of_test();
  end
endmodule
